// ---- hw/pde_pkg.sv ----
package pde_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned APB_ADDR_W        = 8;
  localparam int unsigned REG_W             = 16;
  localparam logic [7:0]  OFS_PD_LOW_CTRL1  = 8'h00;
  localparam logic [7:0]  OFS_PE_DIR_LOW    = 8'h04;
  localparam logic [7:0]  OFS_PE_CTRL_LOW1  = 8'h08;
  localparam logic [7:0]  OFS_PE_CTRL_LOW2  = 8'h0C;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RST_PD_LOW_CTRL1  = 16'h0000;
  localparam logic [7:0]  RST_PD_EXT_MODE   = 8'hFF;
  localparam logic [15:0] RST_PE_DIR_LOW    = 16'h0000;
  localparam logic [15:0] RST_PE_CTRL_LOW1  = 16'h0000;
  localparam logic [15:0] RST_PE_CTRL_LOW2  = 16'h0000;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned PD_SEL_LSB        = 0;
  localparam int unsigned PD_SEL_W          = 8;
  localparam int unsigned PE_MUX_FIRST_PIN  = 12;
  localparam int unsigned PE_MUX_PINS       = 4;
  localparam int unsigned PE15_SEL_LSB      = 14;
  localparam int unsigned PE14_SEL_LSB      = 12;
  localparam int unsigned PE13_SEL_LSB      = 10;
  localparam int unsigned PE12_SEL_LSB      = 8;

  // ****************************************
  // function codes of a two-bit pin field
  // ****************************************
  localparam logic [1:0]  FN_GPIO           = 2'h0;
  localparam logic [1:0]  FN_TIMER          = 2'h1;
  localparam logic [1:0]  FN_ALT2           = 2'h2;
  localparam logic [1:0]  FN_ALT3           = 2'h3;

  // legal code masks, bit n set when code n is allowed
  localparam logic [3:0]  LEGAL_PD          = 4'h3;
  localparam logic [3:0]  LEGAL_PE15        = 4'hF;
  localparam logic [3:0]  LEGAL_PE14        = 4'h7;
  localparam logic [3:0]  LEGAL_PE13        = 4'h7;
  localparam logic [3:0]  LEGAL_PE12        = 4'hB;

  // level delivered to an input of a function that is not selected
  localparam logic [3:0]  IDLE_IN_PD        = 4'h0;
  localparam logic [3:0]  IDLE_IN_PE13      = 4'h4;
  localparam logic [3:0]  IDLE_IN_PE        = 4'h0;

endpackage

// ---- hw/pde_pin_mux.sv ----
// ****************************************
// one multiplexed pin: four candidate functions
// ****************************************
module pde_pin_mux
  import pde_pkg::*;
#(
  parameter logic [3:0] LEGAL   = 4'hF,
  parameter logic [3:0] IDLE_IN = 4'h0
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] sel,
  input  wire logic [3:0] src_out,
  input  wire logic [3:0] src_oe,
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  output logic [3:0]      fn_in
);

  logic       pin_out_r;
  logic       pin_out_nxt;
  logic       pin_oe_r;
  logic       pin_oe_nxt;
  logic [3:0] fn_in_r;
  logic [3:0] fn_in_nxt;

  // route the selected source to the pin and the pin to that source only
  always_comb begin
    pin_out_nxt = 1'b0;
    pin_oe_nxt  = 1'b0;
    fn_in_nxt   = IDLE_IN;
    if (LEGAL[sel]) begin
      pin_out_nxt    = src_out[sel];
      pin_oe_nxt     = src_oe[sel];
      fn_in_nxt[sel] = pin_in;
    end
    // a prohibited code leaves the pin undriven
  end

  // registered pin side
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out_r <= 1'b0;
      pin_oe_r  <= 1'b0;
      fn_in_r   <= IDLE_IN; // no false active-low strobe during reset
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
      fn_in_r   <= fn_in_nxt;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe  = pin_oe_r;
  assign fn_in   = fn_in_r;

endmodule

// ---- hw/pde_pin_func_sel.sv ----
// Summary of operation
// - port D bits 7:0 pick GPIO or data
// - port D bits reset 0, 1 in expansion
// - port E direction is 16-bit read/write
// - direction 1 drives output, 0 input
// - port E direction resets to zero
// - direction used only for GPIO and timer
// - pin 15: GPIO, timer D, DMA ack1, IRQ
// - pin 14: GPIO, timer C, DMA ack0
// - pin 13: GPIO, timer B, manual reset
// - pin 12: GPIO, timer A, serial3 transmit
// - port E control L1, L2 16-bit read/write
module pde_pin_func_sel
  import pde_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // strap: chip started in ROM disabled external-expansion mode
  input  wire logic                  rom_disabled_ext_mode,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // port D low pins
  input  wire logic [7:0]            portd_pin_in,
  output logic [7:0]                 portd_pin_out,
  output logic [7:0]                 portd_pin_oe,
  input  wire logic [7:0]            portd_gpio_out,
  input  wire logic [7:0]            portd_gpio_oe,
  output logic [7:0]                 portd_gpio_in,
  input  wire logic [7:0]            ext_bus_data_out,
  input  wire logic [7:0]            ext_bus_data_oe,
  output logic [7:0]                 ext_bus_data_in,
  // port E pins 15:12
  input  wire logic [3:0]            porte_pin_in,
  output logic [3:0]                 porte_pin_out,
  output logic [3:0]                 porte_pin_oe,
  input  wire logic [3:0]            porte_gpio_out,
  output logic [3:0]                 porte_gpio_in,
  // timer channel 4, index 0..3 is a..d
  input  wire logic [3:0]            timer_ch4_out,
  output logic [3:0]                 timer_ch4_in,
  input  wire logic                  dma_ack_0,
  input  wire logic                  dma_ack_1,
  input  wire logic                  interrupt_request_out,
  output logic                       manual_reset_in_b,
  input  wire logic                  serial3_transmit,
  // register values for the rest of port E
  output logic [15:0]                porte_direction,
  output logic [15:0]                porte_function_ctrl_low2
);

  // ****************************************
  // register state
  // ****************************************
  logic [15:0] port_d_low_function_ctrl1_r;
  logic [15:0] port_d_low_function_ctrl1_nxt;
  logic [15:0] port_e_direction_low_r;
  logic [15:0] port_e_direction_low_nxt;
  logic [15:0] port_e_function_ctrl_low1_r;
  logic [15:0] port_e_function_ctrl_low1_nxt;
  logic [15:0] port_e_function_ctrl_low2_r;
  logic [15:0] port_e_function_ctrl_low2_nxt;
  logic        strap_done_r;
  logic        strap_done_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // ****************************************
  // apb decode
  // ****************************************
  logic        addr_hit;
  logic        setup_phase;
  logic        write_access;
  logic [15:0] read_word;

  // map the address onto the four registers
  always_comb begin
    addr_hit  = 1'b1;
    read_word = 16'h0000;
    unique case (paddr)
      OFS_PD_LOW_CTRL1: read_word = port_d_low_function_ctrl1_r;
      OFS_PE_DIR_LOW:   read_word = port_e_direction_low_r;
      OFS_PE_CTRL_LOW1: read_word = port_e_function_ctrl_low1_r;
      OFS_PE_CTRL_LOW2: read_word = port_e_function_ctrl_low2_r;
      default:          addr_hit  = 1'b0;
    endcase
  end

  // zero wait state: read data is captured in the setup cycle
  assign setup_phase  = psel & ~penable;
  assign write_access = psel & penable & pwrite & addr_hit;
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~addr_hit;
  assign prdata       = prdata_r;

  // next values of the software registers
  always_comb begin
    port_d_low_function_ctrl1_nxt = port_d_low_function_ctrl1_r;
    port_e_direction_low_nxt      = port_e_direction_low_r;
    port_e_function_ctrl_low1_nxt = port_e_function_ctrl_low1_r;
    port_e_function_ctrl_low2_nxt = port_e_function_ctrl_low2_r;
    strap_done_nxt                = 1'b1;
    prdata_nxt                    = prdata_r;
    // first edge after reset: expansion mode presets the data pins
    if (!strap_done_r && rom_disabled_ext_mode) begin
      port_d_low_function_ctrl1_nxt[PD_SEL_LSB +: PD_SEL_W] = RST_PD_EXT_MODE;
    end
    if (setup_phase) begin
      prdata_nxt = {16'h0000, read_word};
    end
    if (write_access) begin
      unique case (paddr)
        OFS_PD_LOW_CTRL1: port_d_low_function_ctrl1_nxt = pwdata[15:0];
        OFS_PE_DIR_LOW:   port_e_direction_low_nxt      = pwdata[15:0];
        OFS_PE_CTRL_LOW1: port_e_function_ctrl_low1_nxt = pwdata[15:0];
        OFS_PE_CTRL_LOW2: port_e_function_ctrl_low2_nxt = pwdata[15:0];
        default:          prdata_nxt                    = prdata_r;
      endcase
    end
  end

  // register update
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_d_low_function_ctrl1_r <= RST_PD_LOW_CTRL1;
      port_e_direction_low_r      <= RST_PE_DIR_LOW;
      port_e_function_ctrl_low1_r <= RST_PE_CTRL_LOW1;
      port_e_function_ctrl_low2_r <= RST_PE_CTRL_LOW2;
      strap_done_r                <= 1'b0;
      prdata_r                    <= 32'h0000_0000;
    end else begin
      port_d_low_function_ctrl1_r <= port_d_low_function_ctrl1_nxt;
      port_e_direction_low_r      <= port_e_direction_low_nxt;
      port_e_function_ctrl_low1_r <= port_e_function_ctrl_low1_nxt;
      port_e_function_ctrl_low2_r <= port_e_function_ctrl_low2_nxt;
      strap_done_r                <= strap_done_nxt;
      prdata_r                    <= prdata_nxt;
    end
  end

  assign porte_direction          = port_e_direction_low_r;
  assign porte_function_ctrl_low2 = port_e_function_ctrl_low2_r;

  // ****************************************
  // port D low pins
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < PD_SEL_W; gi++) begin : g_pd
      logic [3:0] pd_fn_in;
      // code 0 is GPIO, code 1 is the external data line
      pde_pin_mux #(
        .LEGAL   (LEGAL_PD),
        .IDLE_IN (IDLE_IN_PD)
      ) u_mux (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .sel     ({1'b0, port_d_low_function_ctrl1_r[PD_SEL_LSB + gi]}),
        .src_out ({2'b00, ext_bus_data_out[gi], portd_gpio_out[gi]}),
        .src_oe  ({2'b00, ext_bus_data_oe[gi], portd_gpio_oe[gi]}),
        .pin_in  (portd_pin_in[gi]),
        .pin_out (portd_pin_out[gi]),
        .pin_oe  (portd_pin_oe[gi]),
        .fn_in   (pd_fn_in)
      );
      assign portd_gpio_in[gi]   = pd_fn_in[0];
      assign ext_bus_data_in[gi] = pd_fn_in[1];
    end
  endgenerate

  // ****************************************
  // port E pins 15:12
  // ****************************************
  logic [1:0] pe_sel   [PE_MUX_PINS];
  logic [3:0] pe_out   [PE_MUX_PINS];
  logic [3:0] pe_oe    [PE_MUX_PINS];
  logic [3:0] pe_fn_in [PE_MUX_PINS];
  logic [3:0] pe_dir;

  assign pe_dir = port_e_direction_low_r[PE_MUX_FIRST_PIN +: PE_MUX_PINS];

  // candidate sources per pin; index 0 is pin 12
  always_comb begin
    // direction bits steer GPIO and timer codes only
    for (int i = 0; i < PE_MUX_PINS; i++) begin
      pe_out[i] = {1'b0, 1'b0, timer_ch4_out[i], porte_gpio_out[i]};
      pe_oe[i]  = {1'b0, 1'b0, pe_dir[i], pe_dir[i]};
    end
    // pin 15: dma ack 1 and interrupt request are fixed outputs
    pe_out[3][FN_ALT2] = dma_ack_1;
    pe_oe[3][FN_ALT2]  = 1'b1;
    pe_out[3][FN_ALT3] = interrupt_request_out;
    pe_oe[3][FN_ALT3]  = 1'b1;
    // pin 14: dma ack 0 is a fixed output
    pe_out[2][FN_ALT2] = dma_ack_0;
    pe_oe[2][FN_ALT2]  = 1'b1;
    // pin 13: manual reset is a fixed input
    pe_oe[1][FN_ALT2]  = 1'b0;
    // pin 12: serial 3 transmit is a fixed output
    pe_out[0][FN_ALT3] = serial3_transmit;
    pe_oe[0][FN_ALT3]  = 1'b1;
  end

  // field selection per pin
  assign pe_sel[3] = port_e_function_ctrl_low1_r[PE15_SEL_LSB +: 2];
  assign pe_sel[2] = port_e_function_ctrl_low1_r[PE14_SEL_LSB +: 2];
  assign pe_sel[1] = port_e_function_ctrl_low1_r[PE13_SEL_LSB +: 2];
  assign pe_sel[0] = port_e_function_ctrl_low1_r[PE12_SEL_LSB +: 2];

  generate
    for (gi = 0; gi < PE_MUX_PINS; gi++) begin : g_pe
      // prohibited codes differ per pin
      localparam logic [3:0] LEGAL_SEL = (gi == 3) ? LEGAL_PE15 :
                                         (gi == 2) ? LEGAL_PE14 :
                                         (gi == 1) ? LEGAL_PE13 : LEGAL_PE12;
      localparam logic [3:0] IDLE_SEL  = (gi == 1) ? IDLE_IN_PE13 : IDLE_IN_PE;
      pde_pin_mux #(
        .LEGAL   (LEGAL_SEL),
        .IDLE_IN (IDLE_SEL)
      ) u_mux (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .sel     (pe_sel[gi]),
        .src_out (pe_out[gi]),
        .src_oe  (pe_oe[gi]),
        .pin_in  (porte_pin_in[gi]),
        .pin_out (porte_pin_out[gi]),
        .pin_oe  (porte_pin_oe[gi]),
        .fn_in   (pe_fn_in[gi])
      );
      assign porte_gpio_in[gi] = pe_fn_in[gi][FN_GPIO];
      assign timer_ch4_in[gi]  = pe_fn_in[gi][FN_TIMER];
    end
  endgenerate

  // manual reset reaches the interrupt controller only when selected
  assign manual_reset_in_b = pe_fn_in[1][FN_ALT2];

endmodule

// ---- sim/pde_monitor.sv ----
// ****************************************
// port rule checker
// ****************************************
module pde_monitor
  import pde_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [15:0]           porte_direction,
  input wire logic [15:0]           porte_function_ctrl_low2,
  input wire logic [3:0]            porte_pin_out,
  input wire logic [3:0]            porte_pin_oe,
  input wire logic [3:0]            porte_pin_in,
  input wire logic                  interrupt_request_out,
  input wire logic                  dma_ack_0,
  input wire logic                  serial3_transmit,
  input wire logic                  manual_reset_in_b
);
  logic [15:0] c1_r;
  logic [15:0] c1_nxt;
  logic [15:0] wd_lo;
  logic        acc;
  logic        hit;
  // shadow of the port E control L1 word, built from bus writes
  assign wd_lo  = pwdata[15:0];
  assign acc    = psel && penable && pready;
  assign hit    = paddr inside {OFS_PD_LOW_CTRL1, OFS_PE_DIR_LOW, OFS_PE_CTRL_LOW1,
                                OFS_PE_CTRL_LOW2};
  assign c1_nxt = (acc && pwrite && paddr == OFS_PE_CTRL_LOW1) ? wd_lo : c1_r;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) c1_r <= 16'h0000;
    else c1_r <= c1_nxt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access without ready");
  property p_err; psel && penable |-> pslverr == !hit; endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_dir_wr; acc && pwrite && paddr == OFS_PE_DIR_LOW |=> porte_direction == $past(wd_lo);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");
  property p_dir_rst; $rose(rst_b) |-> porte_direction == 16'h0000; endproperty
  a_dir_rst: assert property (p_dir_rst) else $error("direction not cleared");
  property p_l2_wr;
    acc && pwrite && paddr == OFS_PE_CTRL_LOW2 |=> porte_function_ctrl_low2 == $past(wd_lo);
  endproperty
  a_l2_wr: assert property (p_l2_wr) else $error("control L2 write lost");
  property p_irq;
    c1_r[15:14] == FN_ALT3 |=>
      porte_pin_oe[3] && porte_pin_out[3] == $past(interrupt_request_out);
  endproperty
  a_irq: assert property (p_irq) else $error("pin 15 irq route wrong");
  property p_dack;
    c1_r[13:12] == FN_ALT2 |=> porte_pin_oe[2] && porte_pin_out[2] == $past(dma_ack_0);
  endproperty
  a_dack: assert property (p_dack) else $error("pin 14 dma ack route wrong");
  property p_manual_reset_in;
    c1_r[11:10] == FN_ALT2 |=>
      !porte_pin_oe[1] && manual_reset_in_b == $past(porte_pin_in[1]);
  endproperty
  a_manual_reset_in: assert property (p_manual_reset_in) else $error("pin 13 reset input wrong");
  property p_tx;
    c1_r[9:8] == FN_ALT3 |=> porte_pin_oe[0] && porte_pin_out[0] == $past(serial3_transmit);
  endproperty
  a_tx: assert property (p_tx) else $error("pin 12 transmit route wrong");
  property p_gdir;
    c1_r[9:8] == FN_GPIO |=> porte_pin_oe[0] == $past(porte_direction[12]);
  endproperty
  a_gdir: assert property (p_gdir) else $error("pin 12 gpio direction wrong");
  property p_tdir;
    c1_r[15:14] == FN_TIMER |=> porte_pin_oe[3] == $past(porte_direction[15]);
  endproperty
  a_tdir: assert property (p_tdir) else $error("pin 15 timer direction wrong");
endmodule

// ---- sim/pde_far_model.sv ----
// ****************************************
// package pads and far-side drivers
// ****************************************
module pde_far_model (
  input wire logic        sys_clk,
  input wire logic [7:0]  portd_pin_out,
  input wire logic [7:0]  portd_pin_oe,
  input wire logic [3:0]  porte_pin_out,
  input wire logic [3:0]  porte_pin_oe,
  output logic     [7:0]  portd_pin_in,
  output logic     [3:0]  porte_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] ext_r = 12'h5A3;
  // undriven pads wander to a new pattern every cycle
  always @(posedge sys_clk) ext_r <= {ext_r[10:0], ~ext_r[11]};
  assign portd_pin_in = (portd_pin_out & portd_pin_oe) | (ext_r[7:0] & ~portd_pin_oe);
  assign porte_pin_in = (porte_pin_out & porte_pin_oe) | (ext_r[11:8] & ~porte_pin_oe);
endmodule

// ---- sim/tb_top.sv ----
// ****************************************
// bench top
// ****************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pde_pkg::*;
  logic sys_clk, rst_b, strap, psel, penable, pwrite, pready, pslverr, err, first, chk_en;
  logic dk0, dk1, irq, tx, mr, e_mr;
  logic [APB_ADDR_W-1:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, d;
  logic [7:0] pdi, pdo, pdoe, pgo, pgoe, pgi, xo, xoe, xi, e_o, e_oe, e_gi, e_xi;
  logic [3:0] pei, peo, peoe, ego, egi, to, ti, f_o, f_oe, f_g, f_t;
  logic [15:0] dir, c2, m_pd, m_dir, m_c1, m_c2, lg;
  logic [1:0] s;
  int miscompares, n_compared, cyc, seed = 32'h4295;
  pde_pin_func_sel pde_pin_func_sel_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .rom_disabled_ext_mode(strap), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .portd_pin_in(pdi), .portd_pin_out(pdo), .portd_pin_oe(pdoe), .portd_gpio_out(pgo),
    .portd_gpio_oe(pgoe), .portd_gpio_in(pgi), .ext_bus_data_out(xo), .ext_bus_data_oe(xoe),
    .ext_bus_data_in(xi), .porte_pin_in(pei), .porte_pin_out(peo), .porte_pin_oe(peoe),
    .porte_gpio_out(ego), .porte_gpio_in(egi), .timer_ch4_out(to), .timer_ch4_in(ti),
    .dma_ack_0(dk0), .dma_ack_1(dk1), .interrupt_request_out(irq), .manual_reset_in_b(mr),
    .serial3_transmit(tx), .porte_direction(dir), .porte_function_ctrl_low2(c2));
  pde_far_model pde_far_model_i (.sys_clk(sys_clk), .portd_pin_out(pdo), .portd_pin_oe(pdoe),
    .porte_pin_out(peo), .porte_pin_oe(peoe), .portd_pin_in(pdi), .porte_pin_in(pei));
  // clock, stray-cycle limit and random peripheral sources
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    {pgo, pgoe, xo, xoe} <= $random(seed);
    {ego, to, dk0, dk1, irq, tx} <= 12'($random(seed));
    if (cyc == 5000) begin
      miscompares++;
      finish_test;
    end
  end
  // reference model: expected pins from state before the edge, then register update
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      {m_pd, m_dir, m_c1, m_c2} = '0;
      first = 1;
      chk_en = 0;
    end else begin
      e_oe = (m_pd[7:0] & xoe) | (~m_pd[7:0] & pgoe);
      e_o = (m_pd[7:0] & xo) | (~m_pd[7:0] & pgo);
      // pin inputs are registered: take the pad value seen at this edge
      e_gi = ~m_pd[7:0] & pdi;
      e_xi = m_pd[7:0] & pdi;
      e_mr = 1;
      for (int i = 0; i < 4; i++) begin
        s = m_c1[8+2*i+:2];
        f_g[i] = (s == 0) & pei[i];
        f_t[i] = (s == 1) & pei[i];
        {f_oe[i], f_o[i]} = (s < 2) ? {m_dir[12+i], s[0] ? to[i] : ego[i]} : 2'b00;
      end
      if (m_c1[15:14] > 1) {f_oe[3], f_o[3]} = {1'b1, m_c1[14] ? irq : dk1};
      if (m_c1[13:12] == 2) {f_oe[2], f_o[2]} = {1'b1, dk0};
      if (m_c1[11:10] == 2) e_mr = pei[1];
      if (m_c1[9:8] == 3) {f_oe[0], f_o[0]} = {1'b1, tx};
      if (first && strap) m_pd[7:0] = 8'hFF;
      first = 0;
      if (psel && penable && pwrite && pready)
        case (paddr)
          OFS_PD_LOW_CTRL1: m_pd = pwdata[15:0];
          OFS_PE_DIR_LOW:   m_dir = pwdata[15:0];
          OFS_PE_CTRL_LOW1: m_c1 = pwdata[15:0];
          OFS_PE_CTRL_LOW2: m_c2 = pwdata[15:0];
          default:          ;
        endcase
      chk_en = 1;
    end
  end
  // compare all results mid-cycle
  always @(negedge sys_clk) if (chk_en && rst_b) begin
    chk("pd_oe", e_oe, pdoe);
    chk("pd_out", e_o & e_oe, pdo & pdoe);
    chk("pd_gpio_in", e_gi, pgi);
    chk("pd_bus_in", e_xi, xi);
    chk("pe_oe", f_oe, peoe);
    chk("pe_out", f_o & f_oe, peo & peoe);
    chk("pe_gpio_in", f_g, egi);
    chk("timer_in", f_t, ti);
    chk("manual_reset_in_b", e_mr, mr);
    chk("dir", m_dir, dir);
    chk("ctrl_l2", m_c2, c2);
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
    n_compared++;
    if (v !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
    @(posedge sys_clk);
    penable <= 1;
    // the wait ends at the first edge that sees pready high
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [15:0] e);
    apb(0, ad, 32'h0);
    chk("rdata", e, rd[15:0]);
    chk("rdata_hi", 16'h0000, rd[31:16]);
    chk("slverr", 16'(ad > OFS_PE_CTRL_LOW2), 16'(err));
  endtask
  function automatic logic [15:0] mreg(input logic [7:0] ad);
    return ad == 0 ? m_pd : ad == 4 ? m_dir : ad == 8 ? m_c1 : ad == 12 ? m_c2 : 16'h0;
  endfunction
  // software never writes a prohibited pin code
  function automatic logic [15:0] legal(input logic [15:0] v);
    for (int p = 0; p < 4; p++) if (!lg[4*p+v[8+2*p+:2]]) v[8+2*p+:2] = 2'b00;
    return v;
  endfunction
  task automatic reset_with(input logic st);
    {rst_b, strap} <= {1'b0, st};
    repeat (5) @(posedge sys_clk);
    rst_b <= 1;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    {rst_b, strap, psel, penable, pwrite, paddr, pwdata} = '0;
    {pgo, pgoe, xo, xoe, ego, to, dk0, dk1, irq, tx} = '0;
    lg = {LEGAL_PE15, LEGAL_PE14, LEGAL_PE13, LEGAL_PE12};
    reset_with(1);
    rchk(OFS_PD_LOW_CTRL1, 16'h00FF);
    rchk(OFS_PE_DIR_LOW, 16'h0000);
    reset_with(0);
    rchk(OFS_PD_LOW_CTRL1, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      apb(1, OFS_PE_CTRL_LOW1, legal({4{c[1:0]}} << 8));
      apb(1, OFS_PE_DIR_LOW, $random(seed));
      repeat (20) @(posedge sys_clk);
    end
    for (int k = 0; k < 60; k++) begin
      a = 8'(4 * ($random(seed) & 3));
      d = $random(seed);
      if (a == OFS_PE_CTRL_LOW1) d[15:0] = legal(d[15:0]);
      apb(1, a, d);
      // let the reference model take the write before reading it back
      @(negedge sys_clk);
      rchk(a, mreg(a));
    end
    apb(1, 8'h10, 32'hFFFF);
    rchk(8'h10, 16'h0000);
    rchk(OFS_PE_CTRL_LOW2, m_c2);
    finish_test;
  end
endmodule
bind pde_pin_func_sel pde_monitor pde_monitor_i (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .porte_direction(porte_direction),
  .porte_function_ctrl_low2(porte_function_ctrl_low2), .porte_pin_out(porte_pin_out),
  .porte_pin_oe(porte_pin_oe), .porte_pin_in(porte_pin_in),
  .interrupt_request_out(interrupt_request_out), .dma_ack_0(dma_ack_0),
  .serial3_transmit(serial3_transmit), .manual_reset_in_b(manual_reset_in_b));
